// ==== design/etm_pkg.sv ====
package etm_pkg;

  // Core clock and the two documented times
  localparam int ETM_CLK_HZ = 20_000_000;
  localparam int ETM_TICK_S = 1;
  localparam int ETM_DISC_S = 2;
  localparam int ETM_TICK_CYCLES = ETM_CLK_HZ * ETM_TICK_S;
  localparam int ETM_DISC_CYCLES = ETM_CLK_HZ * ETM_DISC_S;

  // Memory pages and byte positions of the time registers
  localparam logic [2:0] ETM_PAGE_SEC = 3'h1;
  localparam logic [2:0] ETM_PAGE_STAMP = 3'h2;
  localparam logic [2:0] ETM_SEC_BYTE0 = 3'h0;
  localparam logic [2:0] ETM_DISC_BYTE0 = 3'h0;
  localparam logic [2:0] ETM_EOC_BYTE0 = 3'h4;

  // Holding register slots: seconds 0..3, disconnect 4..7, charge_end_time 8..11
  localparam int ETM_SLOTS = 12;
  localparam logic [3:0] ETM_SLOT_SEC = 4'h0;
  localparam logic [3:0] ETM_SLOT_DISC = 4'h4;
  localparam logic [3:0] ETM_SLOT_EOC = 4'h8;

  // Reset values and the answer for bytes this block does not own
  localparam logic [31:0] ETM_TIME_RESET = 32'h0000_0000;
  localparam logic [7:0] ETM_RD_NONE = 8'hFF;

  // Byte write from the bus front end into a memory page
  typedef struct packed {
    logic en;
    logic [2:0] page;
    logic [2:0] idx;
    logic [7:0] data;
  } etm_wr_type;

  // Byte read address into a memory page
  typedef struct packed {
    logic [2:0] page;
    logic [2:0] idx;
  } etm_rd_type;

  // Slot decode result
  typedef struct packed {
    logic hit;
    logic [3:0] slot;
  } etm_slot_type;

endpackage : etm_pkg

// ==== design/etm_divider.sv ====
`timescale 1ns/100ps
module etm_divider
  import etm_pkg::*;
#(
  parameter int DIV = ETM_TICK_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  output logic tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } etm_div_state_type;

  etm_div_state_type st;
  etm_div_state_type next_st;

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle pulse every DIV cycles; runs in sleep as the timebase
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 32'(DIV - 1))
    begin
      next_st.cnt = 32'h0000_0000;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Checks: exactly one pulse per wrap of the count
  a_tick_on_wrap: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    st.cnt == 32'(DIV - 1) |=> tick && st.cnt == 32'h0000_0000)
    else $error("timebase missed its pulse");

  a_tick_only_wrap: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    st.cnt != 32'(DIV - 1) |=> !tick)
    else $error("timebase pulsed early");

endmodule : etm_divider

// ==== design/etm_hold.sv ====
`timescale 1ns/100ps
module etm_hold
  import etm_pkg::*;
#(
  parameter int SLOTS = ETM_SLOTS
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [SLOTS*8-1:0] live,
  input wire logic wr_en,
  input wire logic [3:0] wr_slot,
  input wire logic [7:0] wr_data,
  input wire logic rd_hit,
  input wire logic [3:0] rd_slot,
  output logic [7:0] rd_data
);

  typedef struct packed {
    logic [SLOTS-1:0][7:0] mem;
    logic [7:0] rd_data;
  } etm_hold_state_type;

  etm_hold_state_type st;
  etm_hold_state_type next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot of all slots at once, so a multi-byte read is coherent
  always_comb
  begin
    next_st = st;
    if (load)
      next_st.mem = live;
    // Host writes land here too, so read-back matches what was written
    if (wr_en)
      next_st.mem[wr_slot] = wr_data;
    next_st.rd_data = rd_hit ? st.mem[rd_slot] : ETM_RD_NONE;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign rd_data = st.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Checks: a snapshot is taken whole and then sits still until the next one or a host write
  a_load_all_slots: assert property (@(posedge core_clk) disable iff (!rst_n) // R3 R4
    load && !wr_en |=> st.mem == $past(live))
    else $error("snapshot did not load every slot");

  a_hold_no_drift: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    !load && !wr_en |=> $stable(st.mem))
    else $error("holding slots changed without load or write");

  a_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n) // R10 R11
    wr_en |=> st.mem[$past(wr_slot)] == $past(wr_data))
    else $error("host byte did not reach its holding slot");

  a_read_from_reg: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    rd_hit |=> rd_data == $past(st.mem[rd_slot]))
    else $error("read byte differs from its holding slot");

endmodule : etm_hold

// ==== design/etm_timer.sv ====
`timescale 1ns/100ps
// How it works
// R1: A 32-bit seconds counter advances once per second from the timebase.
// R2: The counter rolls over to zero after all ones; host picks the epoch.
// R3: Host reads come from holding registers, stable while being read.
// R4: Holding registers load a snapshot when the recall command's 8th bit arrives.
// R5: Data line low for two seconds copies seconds into the disconnect stamp.
// R6: After disconnect the standard build sleeps; only the seconds counter runs.
// R7: No-sleep build option records the disconnect stamp but keeps converters running.
// R8: Current turning from charge to discharge copies seconds into charge_end_time stamp.
// R9: All three times are four bytes, 1 s per count, low byte first.
// R10: Seconds sit in page 1 bytes 0-3, volatile and host writable.
// R11: Page 2 holds disconnect stamp in bytes 0-3, charge_end_time in 4-7.
// R12: Low-time count restarts when line goes high; one stamp per low period.
module etm_timer
  import etm_pkg::*;
#(
  parameter int TICK_CYCLES = ETM_TICK_CYCLES,
  parameter int DISC_CYCLES = ETM_DISC_CYCLES,
  parameter bit NO_SLEEP = 1'b0
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic dq_in,
  input wire logic cur_valid,
  input wire logic cur_charging,
  input wire logic recall_bit8,
  input wire etm_wr_type wr,
  input wire etm_rd_type rd,
  output logic [7:0] rd_data,
  output logic sleep_mode,
  output logic conv_enable
);

  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] disc;
    logic [31:0] eoc;
    logic [31:0] low_cnt;
    logic disc_done;
    logic sleep;
    logic conv_en;
    logic was_charging;
  } etm_state_type;

  etm_state_type st;
  etm_state_type next_st;
  logic sec_tick;
  etm_slot_type wr_dec;
  etm_slot_type rd_dec;
  logic disc_fire;
  logic eoc_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Page and byte to holding slot; shared by the write and read paths
  function automatic etm_slot_type slot_of(input logic [2:0] page, input logic [2:0] idx);
    etm_slot_type s;
    s.hit = 1'b0;
    s.slot = 4'h0;
    if (page == ETM_PAGE_SEC && idx < ETM_SEC_BYTE0 + 3'h4)
    begin
      s.hit = 1'b1; // R10
      s.slot = ETM_SLOT_SEC + {1'b0, idx};
    end
    else if (page == ETM_PAGE_STAMP)
    begin
      s.hit = 1'b1; // R11
      s.slot = (idx < ETM_EOC_BYTE0) ? ETM_SLOT_DISC + {1'b0, idx - ETM_DISC_BYTE0}
                                     : ETM_SLOT_EOC + {1'b0, idx - ETM_EOC_BYTE0};
    end
    return s;
  endfunction : slot_of

  // Replace one byte of a time word, byte 0 being bits 7:0
  function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] b,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = w;
    r[b*8 +: 8] = d; // R9
    return r;
  endfunction : put_byte

  assign wr_dec = slot_of(wr.page, wr.idx);
  assign rd_dec = slot_of(rd.page, rd.idx);

  ////////////////////////////////////////////////////////////////////////////
  // Timebase; it keeps running during sleep
  etm_divider #(
    .DIV(TICK_CYCLES)
  ) u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(sec_tick)
  );

  // Event detectors
  assign disc_fire = !dq_in && !st.disc_done && st.low_cnt == 32'(DISC_CYCLES - 1);
  assign eoc_fire = cur_valid && st.conv_en && st.was_charging && !cur_charging;

  ////////////////////////////////////////////////////////////////////////////
  // Live counters, stamps, disconnect and charge_end_time detection
  always_comb
  begin
    next_st = st;
    // Plain binary add: all ones rolls to zero
    if (sec_tick)
      next_st.sec = st.sec + 32'h0000_0001; // R1 R2
    if (wr.en && wr_dec.hit)
    begin
      // A host write to the seconds overrides a tick that lands on the same cycle
      if (wr_dec.slot < ETM_SLOT_DISC)
        next_st.sec = put_byte(st.sec, wr_dec.slot[1:0], wr.data); // R10
      else if (wr_dec.slot < ETM_SLOT_EOC)
        next_st.disc = put_byte(st.disc, wr_dec.slot[1:0], wr.data); // R11
      else
        next_st.eoc = put_byte(st.eoc, wr_dec.slot[1:0], wr.data); // R11
    end
    // Line high restarts the measurement and wakes the part
    if (dq_in)
    begin
      next_st.low_cnt = 32'h0000_0000; // R12
      next_st.disc_done = 1'b0; // R12
      next_st.sleep = 1'b0;
      next_st.conv_en = 1'b1;
    end
    else if (!st.disc_done)
    begin
      next_st.low_cnt = st.low_cnt + 32'h0000_0001;
      if (disc_fire)
      begin
        // Hardware stamp wins over a host write in the same cycle
        next_st.disc = st.sec; // R5
        next_st.disc_done = 1'b1; // R12
        next_st.sleep = !NO_SLEEP; // R6 R7
        next_st.conv_en = NO_SLEEP; // R6 R7
      end
    end
    // Measurements stop while asleep, so direction is not tracked then
    if (cur_valid && st.conv_en)
      next_st.was_charging = cur_charging;
    if (eoc_fire)
      next_st.eoc = st.sec; // R8
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.sec <= ETM_TIME_RESET;
      st.disc <= ETM_TIME_RESET;
      st.eoc <= ETM_TIME_RESET;
      st.conv_en <= 1'b1;
    end
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding registers: the only thing the host ever reads
  etm_hold #(
    .SLOTS(ETM_SLOTS)
  ) u_hold (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(recall_bit8), // R3 R4
    .live({st.eoc, st.disc, st.sec}), // R9
    .wr_en(wr.en && wr_dec.hit),
    .wr_slot(wr_dec.slot),
    .wr_data(wr.data),
    .rd_hit(rd_dec.hit),
    .rd_slot(rd_dec.slot),
    .rd_data(rd_data)
  );

  assign sleep_mode = st.sleep;
  assign conv_enable = st.conv_en;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_recall;
    recall_bit8 && !wr.en;
  endsequence

  sequence s_read_sec0;
    rd.page == ETM_PAGE_SEC && rd.idx == ETM_SEC_BYTE0 && !wr.en && !recall_bit8;
  endsequence

  sequence s_quiet;
    $stable(rd) && !wr.en && !recall_bit8;
  endsequence

  a_sec_tick_inc: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    sec_tick && !wr.en |=> st.sec == $past(st.sec) + 32'h0000_0001)
    else $error("seconds counter did not advance on tick");

  a_sec_rolls_over: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
    sec_tick && !wr.en && st.sec == 32'hFFFF_FFFF |=> st.sec == 32'h0000_0000)
    else $error("seconds counter did not roll to zero");

  a_snap_read_back: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    s_recall ##1 s_quiet ##1 s_read_sec0 |=> rd_data == $past(st.sec[7:0], 3))
    else $error("snapshot byte 0 differs from live count at recall");

  a_hold_stays_still: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    s_quiet ##1 s_quiet |=> $stable(rd_data))
    else $error("read data changed without recall or write");

  a_disc_stamp_taken: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
    disc_fire |=> st.disc == $past(st.sec) && st.disc_done)
    else $error("disconnect stamp not taken after low time");

  a_sleep_after_disc: assert property (@(posedge core_clk) disable iff (!rst_n) // R6 R7
    disc_fire |=> sleep_mode == !NO_SLEEP && conv_enable == NO_SLEEP)
    else $error("sleep state wrong after disconnect");

  a_eoc_stamp_taken: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
    eoc_fire |=> st.eoc == $past(st.sec))
    else $error("charge_end_time stamp not taken");

  a_low_restart: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
    dq_in |=> st.low_cnt == 32'h0000_0000 && !st.disc_done && !sleep_mode)
    else $error("low-time measurement not restarted on high line");

  a_one_stamp_per_low: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
    st.disc_done && !dq_in |=> !disc_fire && $stable(st.low_cnt))
    else $error("second disconnect stamp within one low period");

  a_host_writes_sec: assert property (@(posedge core_clk) disable iff (!rst_n) // R10 R9
    wr.en && wr.page == ETM_PAGE_SEC && wr.idx == 3'h3 |=> st.sec[31:24] == $past(wr.data))
    else $error("host write to seconds byte 3 lost");

  a_sec_low_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R9 R10
    wr.en && wr.page == ETM_PAGE_SEC && wr.idx == 3'h0 |=> st.sec[7:0] == $past(wr.data))
    else $error("host write to seconds byte 0 lost");

  a_sec_mid_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R9 R10
    wr.en && wr.page == ETM_PAGE_SEC && wr.idx == 3'h1 |=> st.sec[15:8] == $past(wr.data))
    else $error("host write to seconds byte 1 lost");

  // A stamp event in the same cycle wins, so those cycles are left out here
  a_disc_low_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
    wr.en && wr.page == ETM_PAGE_STAMP && wr.idx == 3'h0 && !disc_fire |=>
    st.disc[7:0] == $past(wr.data))
    else $error("host write to disconnect byte 0 lost");

  a_eoc_top_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
    wr.en && wr.page == ETM_PAGE_STAMP && wr.idx == 3'h7 && !eoc_fire |=>
    st.eoc[31:24] == $past(wr.data))
    else $error("host write to charge_end_time byte 3 lost");

  // Refused writes must leave every time word alone
  a_refused_sec_hi: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
    wr.en && wr.page == ETM_PAGE_SEC && wr.idx >= 3'h4 && !sec_tick |=> $stable(st.sec))
    else $error("write to a foreign page 1 byte changed the seconds");

  a_refused_pages: assert property (@(posedge core_clk) disable iff (!rst_n) // R10 R11
    wr.en && wr.page != ETM_PAGE_SEC && wr.page != ETM_PAGE_STAMP && !sec_tick && !disc_fire
    && !eoc_fire |=> $stable(st.sec) && $stable(st.disc) && $stable(st.eoc))
    else $error("write outside the time pages changed a time word");

  a_unowned_reads_ff: assert property (@(posedge core_clk) disable iff (!rst_n) // R10 R11
    rd.page != ETM_PAGE_SEC && rd.page != ETM_PAGE_STAMP |=> rd_data == ETM_RD_NONE)
    else $error("read outside the time pages not all ones");

  a_sec_hi_reads_ff: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
    rd.page == ETM_PAGE_SEC && rd.idx >= 3'h4 |=> rd_data == ETM_RD_NONE)
    else $error("read of a foreign page 1 byte not all ones");

  // Live words move only on a tick, a host write or a hardware stamp
  a_sec_holds_still: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    !sec_tick && !wr.en |=> $stable(st.sec))
    else $error("seconds counter moved without a tick");

  a_disc_only_fire: assert property (@(posedge core_clk) disable iff (!rst_n) // R5 R12
    !disc_fire && !wr.en |=> $stable(st.disc))
    else $error("disconnect stamp moved without a disconnect");

  a_eoc_only_fire: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
    !eoc_fire && !wr.en |=> $stable(st.eoc))
    else $error("charge_end_time stamp moved without a turn");

  a_turn_tracked: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
    cur_valid && conv_enable |=> st.was_charging == $past(cur_charging))
    else $error("current direction not tracked while awake");

  // Sleep: a line stuck low must keep the part asleep, only a high level wakes it
  a_disc_count_up: assert property (@(posedge core_clk) disable iff (!rst_n) // R5 R12
    !dq_in && !st.disc_done |=> st.low_cnt == $past(st.low_cnt) + 32'h0000_0001)
    else $error("low-time count did not advance");

  a_sleep_holds: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    sleep_mode && !dq_in |=> sleep_mode)
    else $error("woke from sleep while the line stayed low");

  a_conv_not_sleep: assert property (@(posedge core_clk) disable iff (!rst_n) // R6 R7
    conv_enable != sleep_mode)
    else $error("converter enable and sleep disagree");

  a_awake_variant: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    NO_SLEEP |-> !sleep_mode && conv_enable)
    else $error("no-sleep build went to sleep");

  a_no_eoc_asleep: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    !conv_enable && !wr.en |=> $stable(st.eoc))
    else $error("charge_end_time stamp taken while asleep");

endmodule : etm_timer

// ==== dv/etm_host.sv ====
`timescale 1ns/100ps
module etm_host
  import etm_pkg::*;
(
  input wire logic core_clk,
  output logic dq_in,
  output logic recall_bit8,
  output etm_wr_type wr,
  output etm_rd_type rd,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] rd_data_b
);
  // Word read from the no-sleep build, gathered beside the standard one
  logic [31:0] word_b;

  // Idle bus: line pulled high, no strobes
  initial
  begin
    dq_in = 1'b1;
    word_b = '0;
    recall_bit8 = 1'b0;
    wr = '0;
    rd = '0;
  end

  ////////////////////////////////////////
  // Four byte write, low byte first, a gap cycle between strobes
  task automatic put32(input logic [2:0] pg, input logic [2:0] ix, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      #1;
      wr = '{1'b1, pg, ix + 3'(i), v[8*i +: 8]};
      @(posedge core_clk);
      #1;
      wr.en = 1'b0;
    end
  endtask : put32

  // Four byte read; the byte lands one edge after the address
  task automatic get32(input logic [2:0] pg, input logic [2:0] ix, output logic [31:0] v);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      #1;
      rd = '{pg, ix + 3'(i)};
      @(posedge core_clk);
      #1;
      v[8*i +: 8] = rd_data;
      word_b[8*i +: 8] = rd_data_b;
    end
  endtask : get32

  // Eighth bit of the recall command
  task automatic recall();
    @(posedge core_clk);
    #1;
    recall_bit8 = 1'b1;
    @(posedge core_clk);
    #1;
    recall_bit8 = 1'b0;
  endtask : recall

  // Data line level, changed just after an edge
  task automatic line(input logic lvl);
    @(posedge core_clk);
    #1;
    dq_in = lvl;
  endtask : line
endmodule : etm_host

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
module testbench
  import etm_pkg::*;
;
  localparam int TICK = 10;
  localparam int DISC = 25;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cur_valid = 1'b0;
  logic cur_charging = 1'b0;
  logic dq_in, recall_bit8, sleep_mode, conv_enable, sleep_b, conv_b;
  etm_wr_type wr;
  etm_rd_type rd;
  logic [7:0] rd_data, rd_b;
  logic [31:0] a, b, e;
  int bad_count = 0;
  int checks = 0;

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  // Standard build, and the no-sleep build on the same stimulus
  etm_timer #(.TICK_CYCLES(TICK), .DISC_CYCLES(DISC)) dut (.core_clk(core_clk),
    .rst_n(rst_n), .dq_in(dq_in), .cur_valid(cur_valid), .cur_charging(cur_charging),
    .recall_bit8(recall_bit8), .wr(wr), .rd(rd), .rd_data(rd_data),
    .sleep_mode(sleep_mode), .conv_enable(conv_enable));
  etm_timer #(.TICK_CYCLES(TICK), .DISC_CYCLES(DISC), .NO_SLEEP(1'b1)) dut_b (.core_clk(core_clk),
    .rst_n(rst_n), .dq_in(dq_in), .cur_valid(cur_valid), .cur_charging(cur_charging),
    .recall_bit8(recall_bit8), .wr(wr), .rd(rd), .rd_data(rd_b),
    .sleep_mode(sleep_b), .conv_enable(conv_b));
  etm_host host (.core_clk(core_clk), .dq_in(dq_in), .recall_bit8(recall_bit8), .wr(wr),
    .rd(rd), .rd_data(rd_data), .rd_data_b(rd_b));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One current-sign sample
  task automatic sample(input logic chg);
    @(posedge core_clk);
    #1;
    cur_valid = 1'b1;
    cur_charging = chg;
    @(posedge core_clk);
    #1;
    cur_valid = 1'b0;
  endtask : sample

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Watchdog, well beyond the roughly 600 cycles of the sequence
  initial
  begin
    #200000;
    bad_count++;
    wrap_up();
  end

  ////////////////////////////////////////
  // Main sequence; delays hinge on TICK so the deltas are exact
  initial
  begin
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    host.recall();
    host.get32(ETM_PAGE_STAMP, ETM_DISC_BYTE0, a);
    chk(a, ETM_TIME_RESET);
    host.put32(3'h1, 3'h4, 32'h0);
    host.get32(3'h1, 3'h4, a);
    chk(a, 32'hFFFF_FFFF);
    host.put32(3'h0, 3'h0, 32'h0);
    host.get32(3'h0, 3'h0, a);
    chk(a, 32'hFFFF_FFFF);
    host.put32(ETM_PAGE_SEC, ETM_SEC_BYTE0, 32'h1234_5678);
    host.get32(ETM_PAGE_SEC, ETM_SEC_BYTE0, a);
    chk(a, 32'h1234_5678);
    // Recalls exactly 10 ticks apart
    host.recall();
    host.get32(ETM_PAGE_SEC, ETM_SEC_BYTE0, a);
    repeat (10 * TICK - 10) @(posedge core_clk);
    host.recall();
    host.get32(ETM_PAGE_SEC, ETM_SEC_BYTE0, b);
    chk(b - a, 32'h0000_000A);
    repeat (3 * TICK) @(posedge core_clk);
    host.get32(ETM_PAGE_SEC, ETM_SEC_BYTE0, a);
    chk(a, b);
    // Low byte near the top so twenty ticks roll past all ones
    host.put32(ETM_PAGE_SEC, ETM_SEC_BYTE0, 32'hFFFF_FFF0);
    repeat (20 * TICK) @(posedge core_clk);
    host.recall();
    host.get32(ETM_PAGE_SEC, ETM_SEC_BYTE0, a);
    chk(32'(a < 32'h10), 32'h1);
    host.put32(ETM_PAGE_STAMP, ETM_DISC_BYTE0, 32'hA1B2_C3D4);
    host.put32(ETM_PAGE_STAMP, ETM_EOC_BYTE0, 32'h5566_7788);
    host.get32(ETM_PAGE_STAMP, ETM_DISC_BYTE0, a);
    chk(a, 32'hA1B2_C3D4);
    sample(1'b0);
    host.get32(ETM_PAGE_STAMP, ETM_EOC_BYTE0, a);
    chk(a, 32'h5566_7788);
    sample(1'b1);
    sample(1'b0);
    host.recall();
    host.get32(ETM_PAGE_SEC, ETM_SEC_BYTE0, a);
    host.get32(ETM_PAGE_STAMP, ETM_EOC_BYTE0, e);
    chk(32'(a - e < 32'h2), 32'h1);
    // Low one edge short of the limit, then long enough
    host.line(1'b0);
    repeat (DISC - 2) @(posedge core_clk);
    host.line(1'b1);
    host.recall();
    host.get32(ETM_PAGE_STAMP, ETM_DISC_BYTE0, a);
    chk(a, 32'hA1B2_C3D4);
    chk(32'(sleep_mode), 32'h0);
    host.line(1'b0);
    repeat (DISC) @(posedge core_clk);
    #1;
    chk(32'(sleep_mode), 32'h1);
    chk(32'(conv_enable), 32'h0);
    chk(32'(sleep_b), 32'h0);
    chk(32'(conv_b), 32'h1);
    repeat (3 * TICK) @(posedge core_clk);
    sample(1'b1);
    sample(1'b0);
    host.recall();
    host.get32(ETM_PAGE_SEC, ETM_SEC_BYTE0, a);
    chk(host.word_b, a);
    host.get32(ETM_PAGE_STAMP, ETM_DISC_BYTE0, b);
    chk(host.word_b, b);
    chk(32'(a - b - 32'h3 < 32'h2), 32'h1);
    host.get32(ETM_PAGE_STAMP, ETM_EOC_BYTE0, b);
    chk(b, e);
    // The no-sleep build kept measuring, so its stamp follows the late turn
    chk(32'(a - host.word_b < 32'h2), 32'h1);
    host.line(1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    chk(32'(conv_enable), 32'h1);
    chk(32'(sleep_mode), 32'h0);
    wrap_up();
  end
endmodule : testbench
